// ==== sram32k_pkg.sv ====
// Package for the 32K x 8 static memory host controller
package sram32k_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 20;
  // Minimum read or write cycle time, fastest grade
  localparam int CYCLE_TIME_NS = 85;
  // Output enable to valid data, fastest grade
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS = 40;
  // Write recovery after the earlier control rises
  localparam int WRITE_RECOVERY_NS = 10;
  // Chip enable to end of write
  localparam int WRITE_PULSE_NS = 65;
  // Address setup before output enable falls
  localparam int ADDR_SETUP_NS = 45;
  localparam int CYC_CYCLES = (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OE_ACCESS_CYCLES =
      (OUTPUT_ENABLE_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // Pin to usable word: three stages plus the agreement stage
  localparam int SYNC_LAT_CYCLES = 4;
  localparam int WR_RECOVERY_CYCLES = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_SETUP_CYCLES = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETENTION_RECOVERY_CYCLES = CYC_CYCLES;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [2:0] {
    SRAM_IDLE,
    SRAM_RD_SETUP,
    SRAM_RD_ACCESS,
    SRAM_WR_PULSE,
    SRAM_RECOVER,
    SRAM_RETAIN,
    SRAM_RETAIN_EXIT
  } sram_state_t;
endpackage

// ==== sram_sync3.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sram_sync3 #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;
  logic [WIDTH-1:0] nxt_out;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Change counts only once stages two and three agree
      always_comb begin
        nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : out_ff[i];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign sync_out = out_ff;
endmodule // sram_sync3

// ==== sram_host.sv ====
// Host-side controller driving a 32K x 8 asynchronous static memory
// Notes on behaviour
// [R1] Memory holds 32,768 bytes; 15-bit address, one shared 8-bit data bus.
// [R2] Chip select high deselects the memory; host releases nothing it needs.
// [R3] Controls are plain levels; memory takes no clock from the host.
// [R4] Reads keep write enable high; data valid with select and output enable low.
// [R5] Selected with both enables high gives high-impedance outputs.
// [R6] Write happens while select and write enable both low; host drives data then.
// [R7] Write enable falling before select keeps memory outputs off all write; here write enable falls with select.
// [R8] Output enable high during a write keeps memory outputs off.
// [R9] Write recovery counts from the first control to rise until cycle end.
// [R10] New cycle starts no sooner than 85 ns after the previous start.
// [R11] Read data valid 40 ns after output enable falls, address settled.
// [R12] Holding select high enters retention; contents survive low supply.
// [R13] After retention, wait one read cycle time before the next access.
`timescale 1ns/1ps
module sram_host
  import sram32k_pkg::*;
#(
  parameter int ADDR_WIDTH = sram32k_pkg::ADDR_W,
  parameter int DATA_WIDTH = sram32k_pkg::DATA_W
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [ADDR_WIDTH-1:0] req_addr_in,
  input wire logic [DATA_WIDTH-1:0] req_wdata_in,
  input wire logic retain_req_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [DATA_WIDTH-1:0] rd_data_out,
  output logic retained_out,
  output logic [ADDR_WIDTH-1:0] address_pins_out,
  output logic chip_select_n_out,
  output logic output_enable_n_out,
  output logic write_enable_n_out,
  output logic [DATA_WIDTH-1:0] data_pins_out,
  output logic data_pins_oe_out,
  input wire logic [DATA_WIDTH-1:0] data_pins_in
);
  import sram32k_pkg::*;

  localparam logic [CNT_W-1:0] CYC_N = CNT_W'(CYC_CYCLES);
  localparam logic [CNT_W-1:0] OE_N = CNT_W'(OE_ACCESS_CYCLES + SYNC_LAT_CYCLES);
  localparam logic [CNT_W-1:0] WR_N = CNT_W'(WR_PULSE_CYCLES);
  localparam logic [CNT_W-1:0] REC_N = CNT_W'(WR_RECOVERY_CYCLES);
  localparam logic [CNT_W-1:0] SET_N = CNT_W'(ADDR_SETUP_CYCLES);
  localparam logic [CNT_W-1:0] RET_N = CNT_W'(RETENTION_RECOVERY_CYCLES);

  logic [DATA_WIDTH-1:0] dq_sync;

  sram_sync3 #(
    .WIDTH(DATA_WIDTH)
  ) u_dq_sync (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .async_in(data_pins_in),
    .sync_out(dq_sync)
  );

  sram_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] phase_ff, nxt_phase;
  logic [CNT_W-1:0] cyc_ff, nxt_cyc;
  logic [ADDR_WIDTH-1:0] addr_ff, nxt_addr;
  logic [DATA_WIDTH-1:0] wdata_ff, nxt_wdata;
  logic cs_n_ff, nxt_cs_n;
  logic oe_n_ff, nxt_oe_n;
  logic we_n_ff, nxt_we_n;
  logic doe_ff, nxt_doe;
  logic ready_ff, nxt_ready;
  logic rvalid_ff, nxt_rvalid;
  logic [DATA_WIDTH-1:0] rdata_ff, nxt_rdata;
  logic retained_ff, nxt_retained;
  logic cyc_done;

  // Cycle time runs from each start, independent of phase
  assign cyc_done = (cyc_ff == CNT_ZERO); // [R10]

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = (phase_ff == CNT_ZERO) ? CNT_ZERO : phase_ff - 4'h1;
    nxt_cyc = cyc_done ? CNT_ZERO : cyc_ff - 4'h1;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_cs_n = cs_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_we_n = we_n_ff;
    nxt_doe = doe_ff;
    nxt_ready = 1'b0;
    nxt_rvalid = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_retained = retained_ff;
    unique case (state_ff)
      SRAM_IDLE: begin
        // Idle keeps select high: standby, and memory outputs released
        nxt_cs_n = 1'b1; // [R2] [R3]
        nxt_oe_n = 1'b1;
        nxt_we_n = 1'b1;
        nxt_doe = 1'b0;
        if (retain_req_in) begin
          nxt_state = SRAM_RETAIN; // [R12]
          nxt_retained = 1'b1;
        end else if (req_valid_in && ready_ff) begin
          nxt_addr = req_addr_in; // [R1]
          nxt_wdata = req_wdata_in;
          nxt_cyc = CYC_N - 4'h1; // [R10]
          nxt_cs_n = 1'b0;
          if (req_write_in) begin
            // Write enable falls with select; outputs stay off
            nxt_we_n = 1'b0; // [R6] [R7]
            nxt_doe = 1'b1; // [R6]
            nxt_phase = WR_N - 4'h1;
            nxt_state = SRAM_WR_PULSE;
          end else begin
            // Both enables high first: selected but no data out
            nxt_phase = SET_N - 4'h1; // [R5]
            nxt_state = SRAM_RD_SETUP;
          end
        end else begin
          nxt_ready = cyc_done;
        end
      end
      SRAM_RD_SETUP: begin
        if (phase_ff == CNT_ZERO) begin
          nxt_oe_n = 1'b0; // [R4]
          nxt_phase = OE_N - 4'h1;
          nxt_state = SRAM_RD_ACCESS;
        end
      end
      SRAM_RD_ACCESS: begin
        // Sampling waits out access time and synchroniser; else a stale word
        if (phase_ff == CNT_ZERO) begin
          nxt_rdata = dq_sync; // [R11]
          nxt_rvalid = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cs_n = 1'b1;
          nxt_phase = CNT_ZERO;
          nxt_state = SRAM_RECOVER;
        end
      end
      SRAM_WR_PULSE: begin
        // Output enable held high for the whole write
        nxt_oe_n = 1'b1; // [R8]
        if (phase_ff == CNT_ZERO) begin
          // Write enable rises first; select follows after recovery
          nxt_we_n = 1'b1; // [R9]
          nxt_phase = REC_N;
          nxt_state = SRAM_RECOVER;
        end
      end
      SRAM_RECOVER: begin
        if (phase_ff == CNT_ZERO) begin
          nxt_cs_n = 1'b1; // [R9]
          nxt_doe = 1'b0;
          if (cyc_done) begin
            nxt_state = SRAM_IDLE; // [R10]
          end
        end
      end
      SRAM_RETAIN: begin
        nxt_cs_n = 1'b1; // [R12]
        if (!retain_req_in) begin
          nxt_phase = RET_N;
          nxt_state = SRAM_RETAIN_EXIT;
        end
      end
      SRAM_RETAIN_EXIT: begin
        if (phase_ff == CNT_ZERO) begin
          nxt_retained = 1'b0; // [R13]
          nxt_state = SRAM_IDLE;
        end
      end
      default: begin
        nxt_state = SRAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= SRAM_IDLE;
      phase_ff <= CNT_ZERO;
      cyc_ff <= CNT_ZERO;
      addr_ff <= '0;
      wdata_ff <= '0;
      cs_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      doe_ff <= 1'b0;
      ready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      retained_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      cyc_ff <= nxt_cyc;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      cs_n_ff <= nxt_cs_n;
      oe_n_ff <= nxt_oe_n;
      we_n_ff <= nxt_we_n;
      doe_ff <= nxt_doe;
      ready_ff <= nxt_ready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      retained_ff <= nxt_retained;
    end
  end

  assign req_ready_out = ready_ff;
  assign rd_valid_out = rvalid_ff;
  assign rd_data_out = rdata_ff;
  assign retained_out = retained_ff;
  assign address_pins_out = addr_ff;
  assign chip_select_n_out = cs_n_ff;
  assign output_enable_n_out = oe_n_ff;
  assign write_enable_n_out = we_n_ff;
  assign data_pins_out = wdata_ff;
  assign data_pins_oe_out = doe_ff;
endmodule // sram_host

// ==== sram_host_checker.sv ====
// Assertion checker for the static memory host controller
`timescale 1ns/1ps
module sram_host_checker (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic retain_req_in,
  input wire logic req_ready_out,
  input wire logic rd_valid_out,
  input wire logic retained_out,
  input wire logic [sram32k_pkg::ADDR_W-1:0] address_pins_out,
  input wire logic chip_select_n_out,
  input wire logic output_enable_n_out,
  input wire logic write_enable_n_out,
  input wire logic data_pins_oe_out
);
  import sram32k_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic take;
  assign take = req_valid_in && req_ready_out && !retain_req_in;
  a_read_we_high: assert property (!output_enable_n_out |-> write_enable_n_out)
    else $error("output enable low during write");
  a_write_oe_off: assert property (!write_enable_n_out |-> output_enable_n_out)
    else $error("output enable low while writing");
  a_we_in_select: assert property (!write_enable_n_out |-> !chip_select_n_out)
    else $error("write enable low while deselected");
  a_drive_selected: assert property (data_pins_oe_out |-> !chip_select_n_out)
    else $error("host drives data while deselected");
  a_read_timing: assert property (take && !req_write_in |-> ##1 !chip_select_n_out
    ##3 !output_enable_n_out ##7 rd_valid_out)
    else $error("read walk timing wrong");
  a_write_start: assert property (take && req_write_in |=>
    !write_enable_n_out && data_pins_oe_out && !rd_valid_out)
    else $error("write did not start");
  a_cycle_spacing: assert property (take |=> !req_ready_out [*4])
    else $error("cycles closer than minimum");
  a_retain_entry: assert property (retain_req_in |=> chip_select_n_out && retained_out)
    else $error("retention not entered");
  a_recover_idle: assert property (retained_out |-> !req_ready_out && chip_select_n_out)
    else $error("access during retention recovery");
  a_addr_stable: assert property (!chip_select_n_out && !$past(chip_select_n_out) |->
    $stable(address_pins_out))
    else $error("address moved while selected");
endmodule // sram_host_checker

bind sram_host sram_host_checker u_sram_host_checker (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
  .retain_req_in(retain_req_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
  .retained_out(retained_out), .address_pins_out(address_pins_out),
  .chip_select_n_out(chip_select_n_out), .output_enable_n_out(output_enable_n_out),
  .write_enable_n_out(write_enable_n_out), .data_pins_oe_out(data_pins_oe_out));

// ==== sram_mem_model.sv ====
// Behavioural model of the 32K x 8 static memory on the far side
`timescale 1ns/1ps
module sram_mem_model #(
  parameter int ACC_NS = 30
) (
  input wire logic [14:0] address_pins_in,
  input wire logic chip_select_n_in,
  input wire logic output_enable_n_in,
  input wire logic write_enable_n_in,
  input wire logic [7:0] host_data_in,
  input wire logic host_oe_in,
  output logic [7:0] data_pins_out
);
  logic [7:0] mem [0:32767];
  logic drive;
  wire drive_late;
  // Plain levels, no clock: selected, output enabled and not writing
  assign drive = !chip_select_n_in && !output_enable_n_in && write_enable_n_in;
  // Slow answer inside the access time
  assign #(ACC_NS) drive_late = drive;
  // Released bus shows the inverse word so a stale match cannot pass
  assign data_pins_out = host_oe_in ? host_data_in :
      (drive_late ? mem[address_pins_in] : ~mem[address_pins_in]);
  // Word lands as the overlap closes; a level write races the address
  always @(posedge chip_select_n_in or posedge write_enable_n_in) begin
    if (!chip_select_n_in || !write_enable_n_in) begin
      mem[address_pins_in] <= data_pins_out;
    end
  end
endmodule // sram_mem_model

// ==== static_ram_32k_by_8_test.sv ====
// Self-checking bench for the static memory host controller
`timescale 1ns/1ps
module static_ram_32k_by_8_test;
  import sram32k_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic retain_req = 1'b0;
  logic [ADDR_W-1:0] req_addr = 15'h0000;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic ready, rd_valid, retained, cs_n, oe_n, we_n, dq_oe;
  logic [ADDR_W-1:0] addr_pins;
  logic [DATA_W-1:0] rd_data, dq_out, dq_in;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  always #10 core_clk_in = ~core_clk_in;
  sram_host u_sram_host (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid),
    .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .retain_req_in(retain_req), .req_ready_out(ready), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .retained_out(retained), .address_pins_out(addr_pins),
    .chip_select_n_out(cs_n), .output_enable_n_out(oe_n), .write_enable_n_out(we_n),
    .data_pins_out(dq_out), .data_pins_oe_out(dq_oe), .data_pins_in(dq_in));
  sram_mem_model u_sram_mem_model (.address_pins_in(addr_pins), .chip_select_n_in(cs_n),
    .output_enable_n_in(oe_n), .write_enable_n_in(we_n), .host_data_in(dq_out),
    .host_oe_in(dq_oe), .data_pins_out(dq_in));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Valid drops after the take; returns once the cycle has closed
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    while (ready !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    req_valid = 1'b0;
    while (!wr && rd_valid !== 1'b1) @(negedge core_clk_in);
    while (ready !== 1'b1) @(negedge core_clk_in);
  endtask
  task automatic t_idle();
    check("select", 8'(cs_n), 8'h01);
    check("out enable", 8'(oe_n), 8'h01);
    check("wr enable", 8'(we_n), 8'h01);
    check("data drive", 8'(dq_oe), 8'h00);
    check("retained", 8'(retained), 8'h00);
  endtask
  task automatic t_rw();
    logic [ADDR_W-1:0] a [4] = '{15'h0000, 15'h7FFF, 15'h5555, 15'h2AAA};
    logic [DATA_W-1:0] d [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    foreach (a[i]) begin
      xfer(1'b1, a[i], d[i]);
      check("stored", u_sram_mem_model.mem[a[i]], d[i]);
    end
    foreach (a[i]) begin
      xfer(1'b0, a[i], 8'h00);
      check("read data", rd_data, d[i]);
    end
  endtask
  // A second request held while the first write is busy must be ignored
  task automatic t_refused();
    xfer(1'b1, 15'h0101, 8'h33);
    req_write = 1'b1;
    req_addr = 15'h0100;
    req_wdata = 8'h11;
    req_valid = 1'b1;
    while (ready !== 1'b1) @(negedge core_clk_in);
    @(negedge core_clk_in);
    req_addr = 15'h0101;
    req_wdata = 8'h22;
    repeat (2) @(negedge core_clk_in);
    req_valid = 1'b0;
    repeat (12) @(negedge core_clk_in);
    check("busy write", u_sram_mem_model.mem[15'h0101], 8'h33);
    check("first write", u_sram_mem_model.mem[15'h0100], 8'h11);
  endtask
  task automatic t_retain();
    int n = 0;
    xfer(1'b1, 15'h1234, 8'hC3);
    req_valid = 1'b0;
    repeat (10) @(negedge core_clk_in);
    req_addr = 15'h1234;
    req_wdata = 8'h00;
    req_valid = 1'b1;
    retain_req = 1'b1;
    repeat (10) @(negedge core_clk_in);
    check("in retention", 8'(retained), 8'h01);
    check("select held", 8'(cs_n), 8'h01);
    req_valid = 1'b0;
    retain_req = 1'b0;
    while (retained === 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk_in);
    end
    check("recovery wait", 8'(n >= RETENTION_RECOVERY_CYCLES), 8'h01);
    xfer(1'b0, 15'h1234, 8'h00);
    check("kept data", rd_data, 8'hC3);
  endtask
  initial begin
    repeat (20) @(negedge core_clk_in);
    rst_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    t_idle();
    t_rw();
    t_refused();
    t_retain();
    wrap_up();
  end
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end
endmodule // static_ram_32k_by_8_test
